// *** pkg/usi_i2c_pkg.sv ***
// ****************************************
// constants for the i2c slave engine
// ****************************************
package usi_i2c_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 11;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CR1  = 8'hD9;
	localparam logic [7:0] IDX_CR2  = 8'hDA;
	localparam logic [7:0] IDX_CR3  = 8'hDB;
	localparam logic [7:0] IDX_CR4  = 8'hDC;
	localparam logic [7:0] IDX_SAR  = 8'hDD;
	localparam logic [7:0] IDX_PIN  = 8'hE0;
	localparam logic [7:0] IDX_ST1  = 8'hE1;
	localparam logic [7:0] IDX_ST2  = 8'hE2;
	localparam logic [7:0] IDX_BD   = 8'hE3;
	localparam logic [7:0] IDX_HOLD = 8'hE4;
	localparam logic [7:0] IDX_DATA = 8'hE5;
	localparam logic [7:0] IDX_LOW  = 8'hE6;
	localparam logic [7:0] IDX_HIGH = 8'hE7;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ST1  = 8'h80;
	localparam logic [7:0] RST_BD   = 8'hFF;
	localparam logic [7:0] RST_HOLD = 8'h01;
	localparam logic [7:0] RST_SCL  = 8'h3F;
	// field positions and codes
	localparam int         MODE_MSB    = 7;
	localparam int         MODE_LSB    = 6;
	localparam logic [1:0] MODE_I2C    = 2'h2;
	localparam int         EN_BIT      = 1;
	localparam int         MASTER_BIT  = 7;
	localparam int         IE_BIT      = 0;
	localparam int         ACK_EN_BIT  = 3;
	localparam int         GCE_BIT     = 0;
	localparam logic [7:0] GCALL_ADDR  = 8'h00;
	// status two flag positions
	localparam int ST_TEND = 0;
	localparam int ST_SSEL = 1;
	localparam int ST_STOP = 2;
	localparam int ST_RACK = 3;
	localparam int ST_TXM  = 4;
	localparam int ST_GC   = 5;
	// timing figures in system clock periods, then bit counts per byte and per frame
	localparam logic [CNT_W-1:0] SCL_MULT       = 11'h004;
	localparam logic [CNT_W-1:0] SCL_HIGH_EXTRA = 11'h002;
	localparam logic [CNT_W-1:0] SCL_LOW_EXTRA  = 11'h00E;
	localparam logic [3:0]       BITS_DATA      = 4'h8;
	localparam logic [3:0]       BITS_FRAME     = 4'h9;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_ADDR = 5'h02,
		S_XFER = 5'h04,
		S_HOLD = 5'h08,
		S_WAIT = 5'h10
	} slave_state_e;
endpackage

// *** rtl/sync_edge.sv ***
// ****************************************
// two-flop synchroniser with edge finder
// ****************************************
module sync_edge (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			last_reg <= 1'b1;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	// edges look only at the second and third stages
	assign level = sync_reg;
	assign rise  = sync_reg & ~last_reg;
	assign fall  = ~sync_reg & last_reg;
endmodule // sync_edge

// *** rtl/usi_i2c_slave_engine.sv ***
// The Avalon-MM register port was left to the implementer.
module usi_i2c_slave_engine
	import usi_i2c_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [3:0]        byteenable,
	input  wire logic [DATA_W-1:0] writedata,
	output logic      [DATA_W-1:0] readdata,
	output logic                   waitrequest,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   scl_out,
	output logic                   scl_oe,
	output logic                   sda_out,
	output logic                   sda_oe,
	output logic                   irq
);
	// ****************************************
	// declarations
	// ****************************************
	logic [7:0]       cr1_reg, cr2_reg, cr3_reg, cr4_reg, sar_reg, st1_reg;
	logic [7:0]       bd_reg, hold_reg, low_reg, high_reg, tx_buf_reg, rx_buf_reg;
	logic [5:0]       flag_reg;
	logic             wait_reg;
	slave_state_e     state_reg;
	logic [3:0]       bit_cnt_reg;
	logic [7:0]       rx_sh_reg, tx_sh_reg;
	logic             tx_mode_reg, ack_seen_reg, nack_sent_reg, after_data_reg, gc_reg;
	logic             set_ssel_reg, set_tend_reg, set_stop_reg, hold_set_reg;
	logic             drv_go_reg, drv_val_reg, drv_scl_reg;
	logic             busy_reg, pend_val_reg, pend_scl_reg, scl_hold_reg;
	logic [7:0]       hold_cnt_reg;
	logic [CNT_W-1:0] mcnt_reg;
	logic             mlow_reg;
	logic             scl_lv, scl_rise, scl_fall, sda_lv, sda_rise, sda_fall;
	logic             active, start_det, stop_det, addr_hit, release_wr;
	logic             rd_take, wr_do;
	logic [7:0]       eff_idx;

	// ****************************************
	// pin synchronisers
	// ****************************************
	sync_edge u_scl_sync (
		.clock (clock),
		.rst   (rst),
		.pin   (scl_in),
		.level (scl_lv),
		.rise  (scl_rise),
		.fall  (scl_fall)
	);

	sync_edge u_sda_sync (
		.clock (clock),
		.rst   (rst),
		.pin   (sda_in),
		.level (sda_lv),
		.rise  (sda_rise),
		.fall  (sda_fall)
	);

	// ****************************************
	// register bus
	// ****************************************
	function automatic logic [7:0] map_idx(input logic [7:0] idx, input logic i2c);
		map_idx = (i2c && idx == IDX_BD) ? IDX_SAR : idx;
	endfunction

	assign active     = cr2_reg[EN_BIT] && cr1_reg[MODE_MSB:MODE_LSB] == MODE_I2C;
	assign eff_idx    = map_idx(address[ADDR_W-1:2], cr1_reg[MODE_MSB:MODE_LSB] == MODE_I2C);
	assign rd_take    = read & wait_reg;
	assign wr_do      = write & ~wait_reg & byteenable[0];
	assign release_wr = wr_do && eff_idx == IDX_ST2;
	assign waitrequest = wait_reg;

	// one wait cycle on every access, then the answer
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			wait_reg <= 1'b1;
		else
			wait_reg <= ~((read | write) & wait_reg);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			readdata <= '0;
		end else if (rd_take) begin
			readdata <= '0;
			unique case (eff_idx)
				IDX_CR1:  readdata[7:0] <= cr1_reg;
				IDX_CR2:  readdata[7:0] <= cr2_reg;
				IDX_CR3:  readdata[7:0] <= cr3_reg;
				IDX_CR4:  readdata[7:0] <= cr4_reg;
				IDX_SAR:  readdata[7:0] <= sar_reg;
				IDX_PIN:  readdata[1:0] <= {sda_lv, scl_lv};
				IDX_ST1:  readdata[7:0] <= st1_reg;
				IDX_ST2:  readdata[5:0] <= flag_reg;
				IDX_BD:   readdata[7:0] <= bd_reg;
				IDX_HOLD: readdata[7:0] <= hold_reg;
				IDX_DATA: readdata[7:0] <= rx_buf_reg;
				IDX_LOW:  readdata[7:0] <= low_reg;
				IDX_HIGH: readdata[7:0] <= high_reg;
				default:  readdata      <= '0;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cr1_reg    <= RST_ZERO;
			cr2_reg    <= RST_ZERO;
			cr3_reg    <= RST_ZERO;
			cr4_reg    <= RST_ZERO;
			sar_reg    <= RST_ZERO;
			st1_reg    <= RST_ST1;
			bd_reg     <= RST_BD;
			hold_reg   <= RST_HOLD;
			low_reg    <= RST_SCL;
			high_reg   <= RST_SCL;
			tx_buf_reg <= RST_ZERO;
		end else if (wr_do) begin
			unique case (eff_idx)
				IDX_CR1:  cr1_reg    <= writedata[7:0];
				IDX_CR2:  cr2_reg    <= writedata[7:0];
				IDX_CR3:  cr3_reg    <= writedata[7:0];
				IDX_CR4:  cr4_reg    <= writedata[7:0];
				IDX_SAR:  sar_reg    <= writedata[7:0];
				IDX_ST1:  st1_reg    <= writedata[7:0];
				IDX_BD:   bd_reg     <= writedata[7:0];
				IDX_HOLD: hold_reg   <= writedata[7:0];
				IDX_DATA: tx_buf_reg <= writedata[7:0];
				IDX_LOW:  low_reg    <= writedata[7:0];
				IDX_HIGH: high_reg   <= writedata[7:0];
				default:  ;
			endcase
		end
	end

	// ****************************************
	// status flags and interrupt
	// ****************************************
	// a hardware set in the clearing cycle survives the clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flag_reg <= '0;
		end else begin
			if (release_wr)
				flag_reg[ST_STOP:ST_TEND] <= '0;
			if (set_tend_reg)
				flag_reg[ST_TEND] <= 1'b1;
			if (set_ssel_reg)
				flag_reg[ST_SSEL] <= 1'b1;
			if (set_stop_reg)
				flag_reg[ST_STOP] <= 1'b1;
			flag_reg[ST_RACK] <= ack_seen_reg;
			flag_reg[ST_TXM]  <= tx_mode_reg;
			flag_reg[ST_GC]   <= gc_reg;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= cr4_reg[IE_BIT] & |flag_reg[ST_STOP:ST_TEND];
	end

	// ****************************************
	// slave sequencer
	// ****************************************
	assign start_det = sda_fall & scl_lv;
	assign stop_det  = sda_rise & scl_lv;
	assign addr_hit  = rx_sh_reg[7:1] == sar_reg[7:1]
		|| (sar_reg[GCE_BIT] && rx_sh_reg == GCALL_ADDR);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg      <= S_IDLE;
			bit_cnt_reg    <= '0;
			rx_sh_reg      <= '0;
			tx_sh_reg      <= '0;
			rx_buf_reg     <= RST_ZERO;
			tx_mode_reg    <= 1'b0;
			ack_seen_reg   <= 1'b0;
			nack_sent_reg  <= 1'b0;
			after_data_reg <= 1'b0;
			gc_reg         <= 1'b0;
			set_ssel_reg   <= 1'b0;
			set_tend_reg   <= 1'b0;
			set_stop_reg   <= 1'b0;
			hold_set_reg   <= 1'b0;
			drv_go_reg     <= 1'b0;
			drv_val_reg    <= 1'b0;
			drv_scl_reg    <= 1'b0;
		end else begin
			set_ssel_reg <= 1'b0;
			set_tend_reg <= 1'b0;
			set_stop_reg <= 1'b0;
			hold_set_reg <= 1'b0;
			drv_go_reg   <= 1'b0;
			if (!active) begin
				state_reg <= S_IDLE;
			end else if (stop_det) begin
				set_stop_reg <= state_reg != S_IDLE;
				state_reg    <= S_IDLE;
				drv_go_reg   <= 1'b1;
				drv_val_reg  <= 1'b0;
				drv_scl_reg  <= 1'b1;
			end else if (start_det) begin
				state_reg   <= S_ADDR;
				bit_cnt_reg <= '0;
				drv_go_reg  <= 1'b1;
				drv_val_reg <= 1'b0;
				drv_scl_reg <= 1'b1;
			end else begin
				unique case (state_reg)
					S_ADDR, S_XFER: begin
						if (scl_rise) begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg < BITS_DATA)
								rx_sh_reg <= {rx_sh_reg[6:0], sda_lv};
							else
								ack_seen_reg <= ~sda_lv;
							if (bit_cnt_reg == BITS_DATA - 4'h1 && state_reg == S_XFER
								&& !tx_mode_reg)
								rx_buf_reg <= {rx_sh_reg[6:0], sda_lv};
						end
						if (scl_fall && bit_cnt_reg == BITS_DATA) begin
							drv_go_reg  <= 1'b1;
							drv_scl_reg <= 1'b0;
							drv_val_reg <= 1'b0;
							if (state_reg == S_ADDR) begin
								if (addr_hit && cr4_reg[ACK_EN_BIT]) begin
									drv_val_reg <= 1'b1;
									tx_mode_reg <= rx_sh_reg[0];
									gc_reg      <= rx_sh_reg == GCALL_ADDR;
								end else begin
									state_reg <= S_IDLE;
								end
							end else if (!tx_mode_reg) begin
								drv_val_reg   <= cr4_reg[ACK_EN_BIT];
								nack_sent_reg <= ~cr4_reg[ACK_EN_BIT];
							end
						end
						if (scl_fall && bit_cnt_reg == BITS_FRAME) begin
							hold_set_reg   <= 1'b1;
							set_ssel_reg   <= state_reg == S_ADDR;
							set_tend_reg   <= state_reg == S_XFER;
							after_data_reg <= state_reg == S_XFER;
							state_reg      <= S_HOLD;
							drv_go_reg     <= 1'b1;
							drv_val_reg    <= 1'b0;
							drv_scl_reg    <= 1'b0;
						end
						if (scl_fall && state_reg == S_XFER && tx_mode_reg
							&& bit_cnt_reg != '0 && bit_cnt_reg < BITS_DATA) begin
							tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
							drv_go_reg  <= 1'b1;
							drv_val_reg <= ~tx_sh_reg[6];
							drv_scl_reg <= 1'b0;
						end
					end
					S_HOLD: begin
						if (release_wr) begin
							drv_go_reg  <= 1'b1;
							drv_scl_reg <= 1'b1;
							drv_val_reg <= 1'b0;
							bit_cnt_reg <= '0;
							if (after_data_reg
								&& (tx_mode_reg ? !ack_seen_reg : nack_sent_reg)) begin
								state_reg <= S_WAIT;
							end else begin
								state_reg <= S_XFER;
								if (tx_mode_reg) begin
									// first bit is set up before the clock is let go
									tx_sh_reg   <= tx_buf_reg;
									drv_val_reg <= ~tx_buf_reg[7];
								end
							end
						end
					end
					S_IDLE, S_WAIT: ;
				endcase
			end
		end
	end

	// ****************************************
	// open-drain drivers with hold delay
	// ****************************************
	// counting from the registered request keeps the change at hold plus two
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_reg     <= 1'b0;
			hold_cnt_reg <= '0;
			pend_val_reg <= 1'b0;
			pend_scl_reg <= 1'b0;
			sda_oe       <= 1'b0;
			scl_hold_reg <= 1'b0;
		end else if (!active) begin
			busy_reg     <= 1'b0;
			sda_oe       <= 1'b0;
			scl_hold_reg <= 1'b0;
		end else begin
			if (hold_set_reg)
				scl_hold_reg <= 1'b1;
			if (drv_go_reg) begin
				busy_reg     <= 1'b1;
				hold_cnt_reg <= hold_reg;
				pend_val_reg <= drv_val_reg;
				pend_scl_reg <= drv_scl_reg;
			end else if (busy_reg) begin
				if (hold_cnt_reg == '0) begin
					busy_reg <= 1'b0;
					sda_oe   <= pend_val_reg;
					if (pend_scl_reg)
						scl_hold_reg <= 1'b0;
				end else begin
					hold_cnt_reg <= hold_cnt_reg - 8'h01;
				end
			end
		end
	end

	// ****************************************
	// master clock timing
	// ****************************************
	// only the clock timing is built; master byte sequencing is not
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mcnt_reg <= '0;
			mlow_reg <= 1'b0;
		end else if (!active || !cr3_reg[MASTER_BIT]) begin
			mcnt_reg <= '0;
			mlow_reg <= 1'b0;
		end else if (mcnt_reg == '0) begin
			mlow_reg <= ~mlow_reg;
			if (mlow_reg)
				mcnt_reg <= SCL_MULT * CNT_W'(high_reg) + SCL_HIGH_EXTRA - 11'h001;
			else
				mcnt_reg <= SCL_MULT * CNT_W'(low_reg) + SCL_LOW_EXTRA - 11'h001;
		end else begin
			mcnt_reg <= mcnt_reg - 11'h001;
		end
	end

	// open drain: the level is always low, only the enable moves
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_oe  <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_oe  <= scl_hold_reg | mlow_reg;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end
endmodule // usi_i2c_slave_engine

// *** sim/i2c_master_model.sv ***
// ****************************************
// bus master on the far side of the link
// ****************************************
module i2c_master_model (
	input  wire logic clock,
	input  wire logic scl_line,
	input  wire logic sda_line,
	output logic      scl_low,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// released clock may be stretched by the slave; bounded so a stuck line ends
	task automatic rise();
		int k;
		k = 0;
		scl_low <= 1'b0;
		do begin
			@(posedge clock);
			k++;
		end while (!scl_line && k < 3000);
		tick(10);
	endtask
	// also serves as repeated start from a held-low clock
	task automatic start();
		sda_low <= 1'b0;
		tick(10);
		rise();
		sda_low <= 1'b1;
		tick(10);
		scl_low <= 1'b1;
		tick(3);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		tick(10);
		rise();
		sda_low <= 1'b0;
		tick(10);
	endtask
	// nine clocks, msb first; nak high leaves the ninth bit released
	task automatic xfer(input logic [7:0] tx, input logic nak, output logic [7:0] rx,
		output logic ack);
		logic [8:0] b;
		b = {tx, nak};
		for (int i = 0; i < 9; i++) begin
			sda_low <= !b[8-i];
			tick(10);
			rise();
			if (i < 8) rx[7-i] = sda_line;
			else ack = !sda_line;
			scl_low <= 1'b1;
			tick(3);
		end
		// let the stretch and the status flags settle before the caller looks
		tick(8);
	endtask
endmodule // i2c_master_model

// *** sim/usi_i2c_slave_engine_checker.sv ***
// ****************************************
// port checker for the slave engine
// ****************************************
module usi_i2c_slave_engine_checker
	import usi_i2c_pkg::*;
(
	input wire logic              clock,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [3:0]        byteenable,
	input wire logic [DATA_W-1:0] writedata,
	input wire logic [DATA_W-1:0] readdata,
	input wire logic              waitrequest,
	input wire logic              scl_in,
	input wire logic              sda_in,
	input wire logic              scl_out,
	input wire logic              scl_oe,
	input wire logic              sda_out,
	input wire logic              sda_oe,
	input wire logic              irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_idx_reg;
	logic [8:0] since_wr_reg;
	logic       mst_on_reg;
	// master clock enable as software last wrote it; its clock is no stretch
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			mst_on_reg <= 1'b0;
		else if (write && !waitrequest && address[9:2] == IDX_CR3)
			mst_on_reg <= writedata[MASTER_BIT];
	end
	// saturating age of the last accepted write
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			last_idx_reg <= 8'h00;
			since_wr_reg <= 9'h1FF;
		end else if (write && !waitrequest) begin
			last_idx_reg <= address[9:2];
			since_wr_reg <= 9'h000;
		end else if (since_wr_reg != 9'h1FF) begin
			since_wr_reg <= since_wr_reg + 9'h001;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered next cycle");
	wait_one_a: assert property ($fell(waitrequest) |=> waitrequest)
		else $error("waitrequest low too long");
	wait_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
		else $error("answer without request");
	rd_upper_a: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
		else $error("readdata upper bits set");
	rd_hold_a: assert property ($changed(readdata) |-> $past(read && waitrequest))
		else $error("readdata moved without read");
	open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("pin driven high");
	stretch_low_a: assert property ($rose(scl_oe) && !mst_on_reg |->
		$past(scl_in, 4) == 1'b0)
		else $error("stretch began in clock high phase");
	release_cause_a: assert property ($fell(scl_oe) && !mst_on_reg && !$past(mst_on_reg, 4) |->
		last_idx_reg == IDX_ST2 && since_wr_reg < 9'h104)
		else $error("clock released without status write");
	sda_timing_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 3))
		else $error("data moved too soon or while clock high");
	cover property ($rose(scl_oe));
	cover property ($rose(irq));
	cover property ($rose(sda_oe));
	cover property ($rose(scl_oe) && mst_on_reg);
endmodule // usi_i2c_slave_engine_checker

bind usi_i2c_slave_engine usi_i2c_slave_engine_checker u_chk (
	.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
);

// *** sim/usi_i2c_slave_engine_tb.sv ***
// ****************************************
// bench for the slave engine
// ****************************************
module usi_i2c_slave_engine_tb
	import usi_i2c_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clock = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] address = 10'h000;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [3:0]        byteenable = 4'hF;
	logic [DATA_W-1:0] writedata = 32'h00000000;
	logic [DATA_W-1:0] readdata;
	logic              waitrequest, scl_out, scl_oe, sda_out, sda_oe, irq;
	logic              scl_low, sda_low, ack;
	logic [7:0]        rd, rx;
	int                fail_count = 0;
	int                samples_checked = 0;
	// pull-ups: a released line reads high
	wire scl_line = !(scl_low || scl_oe);
	wire sda_line = !(sda_low || sda_oe);
	always #2 clock = ~clock;
	usi_i2c_slave_engine u_dut (.clock(clock), .rst(rst), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	i2c_master_model u_master (.clock(clock), .scl_line(scl_line), .sda_line(sda_line),
		.scl_low(scl_low), .sda_low(sda_low));
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	// holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		address <= {idx, 2'b00};
		writedata <= {24'h000000, wd};
		write <= wr;
		read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		rd = readdata[7:0];
		if (waitrequest !== 1'b0) begin
			$display("BAD bus answer expected 0 seen %b", waitrequest);
			fail_count++;
		end
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] m,
		input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(what, exp, rd & m);
	endtask
	task automatic addr(input logic [7:0] a, input logic exp);
		u_master.start();
		u_master.xfer(a, 1'b1, rx, ack);
		chk("addr ack", {7'h00, exp}, {7'h00, ack});
		repeat (8) @(posedge clock);
		chk("scl held", {7'h00, exp}, {7'h00, scl_oe});
		chk("irq", {7'h00, exp}, {7'h00, irq});
	endtask
	task automatic t_regs();
		logic [7:0] ix [13] = '{IDX_CR1, IDX_CR2, IDX_CR3, IDX_CR4, IDX_SAR, IDX_ST1, IDX_ST2,
			IDX_BD, IDX_HOLD, IDX_DATA, IDX_LOW, IDX_HIGH, 8'h00};
		logic [7:0] ex [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'hFF, 8'h01,
			8'h00, 8'h3F, 8'h3F, 8'h00};
		for (int i = 0; i < 13; i++) rdchk("reset value", ix[i], 8'hFF, ex[i]);
		rdchk("pin status", IDX_PIN, 8'h03, 8'h03);
		bus(1'b1, IDX_HIGH, 8'h5A);
		rdchk("high period", IDX_HIGH, 8'hFF, 8'h5A);
		$display("register test done");
	endtask
	task automatic t_rx();
		bus(1'b1, IDX_CR1, 8'h80);
		bus(1'b1, IDX_CR2, 8'h02);
		bus(1'b1, IDX_CR4, 8'h09);
		bus(1'b1, IDX_BD, 8'h54);
		rdchk("own address", IDX_SAR, 8'hFF, 8'h54);
		addr(8'h54, 1'b1);
		rdchk("st2", IDX_ST2, 8'h17, 8'h02);
		bus(1'b1, IDX_ST2, 8'h00);
		u_master.xfer(8'hA5, 1'b1, rx, ack);
		chk("data ack", 8'h01, {7'h00, ack});
		rdchk("st2", IDX_ST2, 8'h07, 8'h01);
		rdchk("rx data", IDX_DATA, 8'hFF, 8'hA5);
		bus(1'b1, IDX_CR4, 8'h01);
		bus(1'b1, IDX_ST2, 8'h00);
		u_master.xfer(8'h3C, 1'b1, rx, ack);
		chk("data nack", 8'h00, {7'h00, ack});
		repeat (8) @(posedge clock);
		chk("scl held", 8'h01, {7'h00, scl_oe});
		rdchk("st2", IDX_ST2, 8'h07, 8'h01);
		bus(1'b1, IDX_CR4, 8'h09);
		bus(1'b1, IDX_ST2, 8'h00);
		u_master.stop();
		rdchk("st2 stop", IDX_ST2, 8'h07, 8'h04);
		chk("irq", 8'h01, {7'h00, irq});
		bus(1'b1, IDX_ST2, 8'h00);
		rdchk("st2 clear", IDX_ST2, 8'h07, 8'h00);
		$display("receiver test done");
	endtask
	task automatic t_tx();
		bus(1'b1, IDX_HOLD, 8'h00);
		rdchk("hold value", IDX_HOLD, 8'hFF, 8'h00);
		addr(8'h55, 1'b1);
		rdchk("st2", IDX_ST2, 8'h17, 8'h12);
		bus(1'b1, IDX_DATA, 8'hC3);
		bus(1'b1, IDX_ST2, 8'h00);
		u_master.xfer(8'hFF, 1'b1, rx, ack);
		chk("tx data", 8'hC3, rx);
		rdchk("st2", IDX_ST2, 8'h07, 8'h01);
		bus(1'b1, IDX_ST2, 8'h00);
		repeat (30) @(posedge clock);
		chk("sda after nack", 8'h00, {7'h00, sda_oe});
		u_master.stop();
		bus(1'b1, IDX_ST2, 8'h00);
		$display("transmitter test done");
	endtask
	task automatic t_misc();
		addr(8'h20, 1'b0);
		u_master.stop();
		rdchk("st2 idle", IDX_ST2, 8'h07, 8'h00);
		addr(8'h00, 1'b0);
		u_master.stop();
		bus(1'b1, IDX_CR4, 8'h01);
		addr(8'h54, 1'b0);
		u_master.stop();
		rdchk("st2 idle", IDX_ST2, 8'h07, 8'h00);
		bus(1'b1, IDX_CR4, 8'h09);
		bus(1'b1, IDX_SAR, 8'h55);
		addr(8'h00, 1'b1);
		rdchk("st2 gcall", IDX_ST2, 8'h27, 8'h22);
		bus(1'b1, IDX_ST2, 8'h00);
		addr(8'h54, 1'b1);
		bus(1'b1, IDX_ST2, 8'h00);
		u_master.stop();
		bus(1'b1, IDX_ST2, 8'h00);
		$display("addressing test done");
	endtask
	task automatic t_mclk();
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		bus(1'b1, IDX_HIGH, 8'h01);
		bus(1'b1, IDX_LOW, 8'h01);
		bus(1'b1, IDX_CR3, 8'h80);
		@(posedge clock iff scl_oe === 1'b1);
		while (scl_oe === 1'b1 && lo < 100) begin
			@(posedge clock);
			lo++;
		end
		while (scl_oe === 1'b0 && hi < 100) begin
			@(posedge clock);
			hi++;
		end
		bus(1'b1, IDX_CR3, 8'h00);
		chk("scl low time", 8'h12, lo[7:0]);
		chk("scl high time", 8'h06, hi[7:0]);
		$display("master clock test done");
	endtask
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_regs();
		t_rx();
		t_tx();
		t_misc();
		t_mclk();
		results();
	end
	// whole run is some thousands of cycles; ten times that margin
	initial begin
		repeat (40000) @(posedge clock);
		fail_count++;
		results();
	end
endmodule // usi_i2c_slave_engine_tb
